// >>> core/ufc_pkg.sv
package ufc_pkg;
   localparam logic [7:0]  OFS_MODE      = 8'h00;
   localparam logic [7:0]  OFS_STAT      = 8'h04;
   localparam logic [7:0]  OFS_TXDATA    = 8'h08;
   localparam logic [7:0]  OFS_RXDATA    = 8'h0C;
   localparam logic [7:0]  OFS_BAUD      = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STS   = 8'h14;
   localparam logic [7:0]  OFS_IRQ_MSK   = 8'h18;
   // Mode field positions
   localparam int          MODE_STOP_BIT_SELECT    = 0;
   localparam int          MODE_PDSEL_LO = 1;
   localparam int          MODE_HIGH_SPEED_BAUD_SELECT     = 3;
   localparam int          MODE_IREN     = 12;
   localparam logic [15:0] MODE_WMASK    = 16'h100F;
   localparam logic [15:0] MODE_RST      = 16'h0000;
   // Status field positions
   localparam int          ST_RXDA       = 0;
   localparam int          ST_OVERRUN_ERROR_FLAG       = 1;
   localparam int          ST_FRAMING_ERROR_FLAG       = 2;
   localparam int          ST_PARITY_ERROR_FLAG       = 3;
   localparam int          ST_RX_LINE_IDLE      = 4;
   localparam int          ST_TX_SHIFT_EMPTY       = 8;
   localparam int          ST_TXBF       = 9;
   localparam int          ST_TXEN       = 10;
   // Interrupt event bits
   localparam int          EV_RX         = 0;
   localparam int          EV_TX         = 1;
   localparam int          EV_PARITY_ERROR_FLAG       = 2;
   localparam int          EV_FRAMING_ERROR_FLAG       = 3;
   localparam int          EV_OVERRUN_ERROR_FLAG       = 4;
   localparam int          EV_NUM        = 5;
   localparam logic [15:0] BAUD_RST      = 16'h0000;
   localparam logic [3:0]  TICKS_STD_M1  = 4'hF;
   localparam logic [3:0]  TICKS_HS_M1   = 4'h3;
   localparam logic [3:0]  IR_PULSE      = 4'h3;
   localparam logic [1:0]  PD_8N         = 2'h0;
   localparam logic [1:0]  PD_8E         = 2'h1;
   localparam logic [1:0]  PD_8O         = 2'h2;
   localparam logic [1:0]  PD_9N         = 2'h3;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_st_t;
endpackage : ufc_pkg

// >>> core/ufc_tx.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_tx import ufc_pkg::*; (
   input  wire logic        i_core_clk, // Core clock
   input  wire logic        i_rst,      // Async reset, high
   input  wire logic        i_tick,     // Sampling clock strobe
   input  wire logic        i_high_speed_baud_select,     // High-speed select
   input  wire logic        i_ir,       // Pulse coding active
   input  wire logic        i_load,     // Take a frame
   input  wire logic [11:0] i_frame,    // Start, data, parity, stops
   input  wire logic [3:0]  i_nbits,    // Bits in frame
   output logic             o_ready,    // Idle, may load
   output logic             o_line,     // Serial output
   output logic [3:0]       o_phase     // Tick within bit
);
   typedef struct packed {
      logic        busy;
      logic [11:0] sh;
      logic [3:0]  left;
      logic [3:0]  ph;
      logic        line;
   } ufc_tx_s_t;
   ufc_tx_s_t q, d;
   always_comb begin
      d = q;
      if (!q.busy) begin
         if (i_load) begin
            d.busy = 1'b1;
            d.sh   = i_frame;
            d.left = i_nbits;
            d.ph   = 4'h0;
         end
      end else if (i_tick) begin
         if (q.ph == (i_high_speed_baud_select ? TICKS_HS_M1 : TICKS_STD_M1)) begin
            d.ph   = 4'h0;
            d.sh   = {1'b1, q.sh[11:1]};
            d.left = q.left - 4'h1;
            if (q.left == 4'h1) d.busy = 1'b0;
         end else begin
            d.ph = q.ph + 4'h1;
         end
      end
      if (i_ir) d.line = d.busy && !d.sh[0] && (d.ph < IR_PULSE);
      else      d.line = d.busy ? d.sh[0] : 1'b1;
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) q <= '{busy: 1'b0, sh: 12'hFFF, left: 4'h0, ph: 4'h0, line: 1'b1};
      else       q <= d;
   end
   assign o_ready = !q.busy;
   assign o_line  = q.line;
   assign o_phase = q.ph;
endmodule : ufc_tx
`default_nettype wire

// >>> core/ufc_rx.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_rx import ufc_pkg::*; (
   input  wire logic       i_core_clk, // Core clock
   input  wire logic       i_rst,      // Async reset, high
   input  wire logic       i_tick,     // Sampling clock strobe
   input  wire logic       i_high_speed_baud_select,     // High-speed select
   input  wire logic [1:0] i_pdsel,    // Parity and data select
   input  wire logic       i_stop_bit_select,    // Two stop bits
   input  wire logic       i_line,     // Decoded serial input
   output logic            o_valid,    // One-cycle word strobe
   output logic [8:0]      o_data,     // Received word
   output logic            o_parity_error_flag,     // Parity mismatch
   output logic            o_framing_error_flag,     // Stop bit low
   output logic            o_idle      // Receiver idle
);
   typedef struct packed {
      ufc_rx_st_t  st;
      logic [3:0]  ph;
      logic [3:0]  n;
      logic [9:0]  sh;
      logic        bad;
      logic        valid;
      logic [8:0]  data;
      logic        parity_error_flag;
      logic        framing_error_flag;
   } ufc_rx_s_t;
   ufc_rx_s_t  q, d;
   logic [3:0] per_m1;
   logic [3:0] nd;
   assign per_m1 = i_high_speed_baud_select ? TICKS_HS_M1 : TICKS_STD_M1;
   assign nd     = (i_pdsel == PD_8N) ? 4'h8 : 4'h9;
   always_comb begin
      d       = q;
      d.valid = 1'b0;
      case (q.st)
         RX_IDLE: if (!i_line) begin
            d.st = RX_START;
            d.ph = 4'h0;
         end
         RX_START: if (i_tick) begin
            if (q.ph == {1'b0, per_m1[3:1]}) begin
               d.st = i_line ? RX_IDLE : RX_DATA;
               d.ph = 4'h0;
               d.n  = 4'h0;
            end else d.ph = q.ph + 4'h1;
         end
         RX_DATA: if (i_tick) begin
            if (q.ph == per_m1) begin
               d.ph = 4'h0;
               d.sh = {i_line, q.sh[9:1]};
               d.n  = q.n + 4'h1;
               if (q.n == nd - 4'h1) begin
                  d.st  = RX_STOP;
                  d.n   = 4'h0;
                  d.bad = 1'b0;
               end
            end else d.ph = q.ph + 4'h1;
         end
         RX_STOP: if (i_tick) begin
            if (q.ph == per_m1) begin
               d.ph  = 4'h0;
               d.bad = q.bad | !i_line;
               if (q.n == {3'h0, i_stop_bit_select}) begin
                  d.st    = RX_IDLE;
                  d.valid = 1'b1;
                  d.framing_error_flag  = d.bad;
                  d.parity_error_flag  = 1'b0;
                  case (i_pdsel)
                     PD_9N:   d.data = q.sh[9:1];
                     PD_8O: begin
                        d.data = {1'b0, q.sh[8:1]};
                        d.parity_error_flag = q.sh[9] != ~^q.sh[8:1];
                     end
                     PD_8E: begin
                        d.data = {1'b0, q.sh[8:1]};
                        d.parity_error_flag = q.sh[9] != ^q.sh[8:1];
                     end
                     default: d.data = {1'b0, q.sh[9:2]};
                  endcase
               end else d.n = q.n + 4'h1;
            end else d.ph = q.ph + 4'h1;
         end
         default: d.st = RX_IDLE;
      endcase
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) q <= '{st: RX_IDLE, default: '0};
      else       q <= d;
   end
   assign o_valid = q.valid;
   assign o_data  = q.data;
   assign o_parity_error_flag  = q.parity_error_flag;
   assign o_framing_error_flag  = q.framing_error_flag;
   assign o_idle  = q.st == RX_IDLE;
endmodule : ufc_rx
`default_nettype wire

// >>> core/ufc_top.sv
// Functional notes
// - High-speed select set: four sampling ticks per serial bit.
// - High-speed select clear: sixteen sampling ticks per serial bit.
// - Field 11 gives nine data bits, 00 eight data bits, no parity.
// - Field 10 gives eight data bits then an odd parity bit.
// - Field 01 gives eight data bits then an even parity bit.
// - Stop select set: two stop bits; clear: one stop bit.
// - Pulse line coding only works while sixteen-tick mode is selected.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ufc_top import ufc_pkg::*; (
   input  wire logic        i_core_clk,      // 100 MHz clock
   input  wire logic        i_rst,           // Async reset, high
   input  wire logic [7:0]  i_s_axi_awaddr,  // Write address
   input  wire logic        i_s_axi_awvalid, // Write address valid
   output logic             o_s_axi_awready, // Write address ready
   input  wire logic [31:0] i_s_axi_wdata,   // Write data
   input  wire logic [3:0]  i_s_axi_wstrb,   // Byte enables
   input  wire logic        i_s_axi_wvalid,  // Write data valid
   output logic             o_s_axi_wready,  // Write data ready
   output logic [1:0]       o_s_axi_bresp,   // Write response
   output logic             o_s_axi_bvalid,  // Write response valid
   input  wire logic        i_s_axi_bready,  // Write response ready
   input  wire logic [7:0]  i_s_axi_araddr,  // Read address
   input  wire logic        i_s_axi_arvalid, // Read address valid
   output logic             o_s_axi_arready, // Read address ready
   output logic [31:0]      o_s_axi_rdata,   // Read data
   output logic [1:0]       o_s_axi_rresp,   // Read response
   output logic             o_s_axi_rvalid,  // Read data valid
   input  wire logic        i_s_axi_rready,  // Read data ready
   input  wire logic        i_rx,            // Serial input
   output logic             o_tx,            // Serial output
   output logic             o_irq            // Level interrupt
);
   typedef struct packed {
      logic               aw_v;
      logic [7:0]         aw_a;
      logic               w_v;
      logic [31:0]        w_d;
      logic [3:0]         w_s;
      logic               b_v;
      logic [1:0]         b_r;
      logic               r_v;
      logic [31:0]        r_d;
      logic [1:0]         r_r;
      logic [15:0]        mode;
      logic               txen;
      logic [15:0]        div;
      logic [15:0]        bcnt;
      logic               tick;
      logic               txb_v;
      logic [8:0]         txb;
      logic               rxb_v;
      logic [8:0]         rxb;
      logic               parity_error_flag;
      logic               framing_error_flag;
      logic               overrun_error_flag;
      logic [3:0]         ir_cnt;
      logic [EV_NUM-1:0]  irq_sts;
      logic [EV_NUM-1:0]  irq_msk;
   } ufc_s_t;
   ufc_s_t      q, d;
   logic        high_speed_baud_select;
   logic [1:0]  pdsel;
   logic        stop_bit_select;
   logic        ir_on;
   logic        rx_line;
   logic        tx_ready;
   logic        tx_load;
   logic [3:0]  tx_phase;
   logic [11:0] frame;
   logic [3:0]  nbits;
   logic        par_bit;
   logic        rx_valid;
   logic [8:0]  rx_data;
   logic        rx_parity_error_flag;
   logic        rx_framing_error_flag;
   logic        rx_idle;
   logic        wr_en;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] stat_word;
   logic [31:0] rd_word;
   logic        rd_ok;
   logic        rd_pop;
   assign high_speed_baud_select   = q.mode[MODE_HIGH_SPEED_BAUD_SELECT];
   assign pdsel  = q.mode[MODE_PDSEL_LO +: 2];
   assign stop_bit_select  = q.mode[MODE_STOP_BIT_SELECT];
   assign ir_on  = q.mode[MODE_IREN] && !high_speed_baud_select;
   // Pulse decode: a short high pulse marks a zero bit
   assign rx_line = ir_on ? !(i_rx || q.ir_cnt != 4'h0) : i_rx;
   // Frame image, LSB first; unused upper bits are stop level
   always_comb begin
      par_bit = (pdsel == PD_8O) ? ~^q.txb[7:0] : ^q.txb[7:0];
      frame   = 12'hFFF;
      frame[0] = 1'b0;
      frame[8:1] = q.txb[7:0];
      case (pdsel)
         PD_9N:        frame[9] = q.txb[8];
         PD_8O, PD_8E: frame[9] = par_bit;
         default:      frame[9] = 1'b1;
      endcase
      nbits = 4'h9 + ((pdsel == PD_8N) ? 4'h0 : 4'h1) + (stop_bit_select ? 4'h2 : 4'h1);
   end
   assign tx_load = tx_ready && q.txb_v && q.txen;
   ufc_tx u_tx (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_tick     (q.tick),
      .i_high_speed_baud_select     (high_speed_baud_select),
      .i_ir       (ir_on),
      .i_load     (tx_load),
      .i_frame    (frame),
      .i_nbits    (nbits),
      .o_ready    (tx_ready),
      .o_line     (o_tx),
      .o_phase    (tx_phase)
   );
   ufc_rx u_rx (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_tick     (q.tick),
      .i_high_speed_baud_select     (high_speed_baud_select),
      .i_pdsel    (pdsel),
      .i_stop_bit_select    (stop_bit_select),
      .i_line     (rx_line),
      .o_valid    (rx_valid),
      .o_data     (rx_data),
      .o_parity_error_flag     (rx_parity_error_flag),
      .o_framing_error_flag     (rx_framing_error_flag),
      .o_idle     (rx_idle)
   );
   assign wr_en = q.aw_v && q.w_v && !q.b_v;
   assign wmask = {{8{q.w_s[3]}}, {8{q.w_s[2]}}, {8{q.w_s[1]}}, {8{q.w_s[0]}}};
   assign wbits = q.w_d & wmask;
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[ST_RXDA]  = q.rxb_v;
      stat_word[ST_OVERRUN_ERROR_FLAG]  = q.overrun_error_flag;
      stat_word[ST_FRAMING_ERROR_FLAG]  = q.framing_error_flag;
      stat_word[ST_PARITY_ERROR_FLAG]  = q.parity_error_flag;
      stat_word[ST_RX_LINE_IDLE] = rx_idle;
      stat_word[ST_TX_SHIFT_EMPTY]  = tx_ready && !q.txb_v;
      stat_word[ST_TXBF]  = q.txb_v;
      stat_word[ST_TXEN]  = q.txen;
   end
   always_comb begin
      rd_ok   = 1'b1;
      rd_word = 32'h0000_0000;
      case (i_s_axi_araddr)
         OFS_MODE:    rd_word = {16'h0000, q.mode};
         OFS_STAT:    rd_word = stat_word;
         OFS_TXDATA:  rd_word = 32'h0000_0000;
         OFS_RXDATA:  rd_word = {23'h000000, q.rxb};
         OFS_BAUD:    rd_word = {16'h0000, q.div};
         OFS_IRQ_STS: rd_word = {27'h0000000, q.irq_sts};
         OFS_IRQ_MSK: rd_word = {27'h0000000, q.irq_msk};
         default:     rd_ok   = 1'b0;
      endcase
   end
   assign rd_pop = i_s_axi_arvalid && !q.r_v && (i_s_axi_araddr == OFS_RXDATA);
   always_comb begin
      d = q;
      // Write channels taken in either order
      if (i_s_axi_awvalid && !q.aw_v && !q.b_v) begin
         d.aw_v = 1'b1;
         d.aw_a = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && !q.w_v && !q.b_v) begin
         d.w_v = 1'b1;
         d.w_d = i_s_axi_wdata;
         d.w_s = i_s_axi_wstrb;
      end
      if (q.b_v && i_s_axi_bready) d.b_v = 1'b0;
      if (q.r_v && i_s_axi_rready) d.r_v = 1'b0;
      if (i_s_axi_arvalid && !q.r_v) begin
         d.r_v = 1'b1;
         d.r_d = rd_ok ? rd_word : 32'h0000_0000;
         d.r_r = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // Baud generator: one tick every div+1 clocks
      d.tick = 1'b0;
      if (q.bcnt >= q.div) begin
         d.bcnt = 16'h0000;
         d.tick = 1'b1;
      end else d.bcnt = q.bcnt + 16'h0001;
      if (i_rx)                             d.ir_cnt = TICKS_STD_M1;
      else if (q.tick && q.ir_cnt != 4'h0) d.ir_cnt = q.ir_cnt - 4'h1;
      if (tx_load) begin
         d.txb_v = 1'b0;
         d.irq_sts[EV_TX] = 1'b1;
      end
      if (rd_pop) d.rxb_v = 1'b0;
      if (wr_en) begin
         d.aw_v = 1'b0;
         d.w_v  = 1'b0;
         d.b_v  = 1'b1;
         d.b_r  = RESP_OKAY;
         case (q.aw_a)
            OFS_MODE:    d.mode = (q.mode & ~(MODE_WMASK & wmask[15:0]))
                                | (q.w_d[15:0] & MODE_WMASK & wmask[15:0]);
            OFS_STAT: begin
               if (wmask[ST_TXEN]) d.txen = q.w_d[ST_TXEN];
               if (wbits[ST_OVERRUN_ERROR_FLAG]) d.overrun_error_flag = 1'b0;
            end
            OFS_TXDATA:  if (!q.txb_v && wmask[0]) begin
               d.txb_v = 1'b1;
               d.txb   = q.w_d[8:0];
            end
            OFS_RXDATA:  ;
            OFS_BAUD:    d.div = (q.div & ~wmask[15:0]) | wbits[15:0];
            OFS_IRQ_STS: d.irq_sts = q.irq_sts & ~wbits[EV_NUM-1:0];
            OFS_IRQ_MSK: d.irq_msk = (q.irq_msk & ~wmask[EV_NUM-1:0]) | wbits[EV_NUM-1:0];
            default:     d.b_r = RESP_SLVERR;
         endcase
      end
      // Hardware events after software clears, so a set wins
      if (rx_valid) begin
         d.irq_sts[EV_RX] = 1'b1;
         if (q.rxb_v && !rd_pop) begin
            d.overrun_error_flag = 1'b1;
            d.irq_sts[EV_OVERRUN_ERROR_FLAG] = 1'b1;
         end else begin
            d.rxb_v = 1'b1;
            d.rxb   = rx_data;
            d.parity_error_flag  = rx_parity_error_flag;
            d.framing_error_flag  = rx_framing_error_flag;
            if (rx_parity_error_flag) d.irq_sts[EV_PARITY_ERROR_FLAG] = 1'b1;
            if (rx_framing_error_flag) d.irq_sts[EV_FRAMING_ERROR_FLAG] = 1'b1;
         end
      end
      if (tx_load) d.irq_sts[EV_TX] = 1'b1;
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         q        <= '0;
         q.mode   <= MODE_RST;
         q.div    <= BAUD_RST;
      end else begin
         q <= d;
      end
   end
   assign o_s_axi_awready = !q.aw_v && !q.b_v;
   assign o_s_axi_wready  = !q.w_v && !q.b_v;
   assign o_s_axi_bvalid  = q.b_v;
   assign o_s_axi_bresp   = q.b_r;
   assign o_s_axi_arready = !q.r_v;
   assign o_s_axi_rvalid  = q.r_v;
   assign o_s_axi_rdata   = q.r_d;
   assign o_s_axi_rresp   = q.r_r;
   assign o_irq           = |(q.irq_sts & q.irq_msk);

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_hs_bit_len: assert property (q.tick && high_speed_baud_select && !tx_ready && tx_phase == 4'h3
                                  |=> tx_phase == 4'h0 || tx_ready)
      else $error("High-speed bit not four ticks");
   a_hs_phase_cap: assert property (high_speed_baud_select && $stable(high_speed_baud_select) |-> tx_ready || tx_phase <= 4'h3)
      else $error("Tick phase beyond four in high-speed mode");
   a_std_bit_len: assert property (q.tick && !high_speed_baud_select && !tx_ready && tx_phase == 4'hF
                                   |=> tx_phase == 4'h0 || tx_ready)
      else $error("Standard bit not sixteen ticks");
   a_std_no_wrap: assert property (q.tick && !high_speed_baud_select && !tx_ready && tx_phase == 4'h7
                                   |=> tx_phase == 4'h8)
      else $error("Standard bit ended early");
   a_frame_len: assert property (tx_load |-> nbits == ((pdsel == PD_8N ? 4'h9 : 4'hA)
                                 + (stop_bit_select ? 4'h2 : 4'h1)))
      else $error("Frame bit count wrong");
   a_nine_bit: assert property (tx_load && pdsel == PD_9N |-> frame[9] == q.txb[8])
      else $error("Ninth data bit lost");
   a_odd_par: assert property (tx_load && pdsel == PD_8O |-> ^frame[9:1] == 1'b1)
      else $error("Odd parity wrong");
   a_even_par: assert property (tx_load && pdsel == PD_8E |-> ^frame[9:1] == 1'b0)
      else $error("Even parity wrong");
   a_stop_level: assert property (tx_load |-> &frame[11:10] && (pdsel != PD_8N || frame[9]))
      else $error("Stop bits not high");
   a_ir_gate: assert property (high_speed_baud_select |-> !ir_on)
      else $error("Pulse coding active in high-speed mode");
   a_par_flag: assert property (rx_valid && pdsel == PD_8N && !q.rxb_v |=> !q.parity_error_flag)
      else $error("Parity error without parity");
   a_irq_level: assert property (|(q.irq_sts & q.irq_msk) |-> o_irq)
      else $error("Interrupt not raised");
   a_wr_resp: assert property (wr_en |=> o_s_axi_bvalid)
      else $error("Write not answered");

   c_hs_frame:  cover property (tx_load && high_speed_baud_select);
   c_par_frame: cover property (rx_valid && pdsel == PD_8O);
   c_two_stop:  cover property (rx_valid && stop_bit_select);
   c_overrun:   cover property (rx_valid && q.rxb_v);
endmodule : ufc_top
`default_nettype wire

// >>> verification/ufc_remote_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufc_remote_model (
   input  wire logic i_core_clk, // Core clock
   output logic      o_line      // Line into the block
);
   initial o_line = 1'h1;

   // Frame bits LSB first; parity spoiled only on request
   function automatic logic [11:0] frame(input logic [8:0] d, input logic [1:0] pd,
                                         input logic st, input logic bad, output int n);
      logic [11:0] f;
      f = 12'hFFF;
      f[0] = 1'h0;
      if (pd == 2'h3) f[9:1] = d;
      else f[8:1] = d[7:0];
      if (pd == 2'h1 || pd == 2'h2) f[9] = ^d[7:0] ^ pd[1] ^ bad;
      n = 10 + int'(pd != 2'h0) + int'(st);
      return f;
   endfunction : frame

   task automatic send(input logic [8:0] d, input logic [1:0] pd, input int p,
                       input logic bad);
      logic [11:0] f;
      int          n;
      f = frame(d, pd, 1'h0, bad, n);
      for (int i = 0; i < n; i++) begin
         o_line <= f[i];
         repeat (p) @(posedge i_core_clk);
      end
   endtask : send
endmodule : ufc_remote_model
`default_nettype wire

// >>> verification/tb_uart_frame_format_config.sv
`timescale 1ns/10ps
`default_nettype none
module tb_uart_frame_format_config import ufc_pkg::*;;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'h0;
   logic        wvalid = 1'h0;
   logic        bready = 1'h0;
   logic        arvalid = 1'h0;
   logic        rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, tx, irq, rx;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, rd;
   int          err_count = 0;
   int          n_checks = 0;

   always #5 clk = ~clk;

   ufc_remote_model i_rem (.i_core_clk(clk), .o_line(rx));

   ufc_top i_dut (
      .i_core_clk(clk), .i_rst(rst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
      .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
      .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .i_rx(rx), .o_tx(tx), .o_irq(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int k = 0; k < 50 && !tb; k++) begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         rs = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tb) bready <= 1'h0;
      end
      chk(tb, 1'h1);
      @(posedge clk);
   endtask : axw

   task automatic axr(input logic [7:0] a);
      logic ta, tr;
      tr = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int k = 0; k < 50 && !tr; k++) begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'h0;
         if (tr) rready <= 1'h0;
      end
      chk(tr, 1'h1);
      @(posedge clk);
   endtask : axr

   // Sends one word and samples every bit of the frame mid-bit
   task automatic t_tx(input logic [1:0] pd, input logic st, input logic hs,
                       input logic [8:0] d);
      logic [11:0] f;
      int          n, p, k;
      p = hs ? 4 : 16;
      k = 0;
      f = i_rem.frame(d, pd, st, 1'h0, n);
      axw(OFS_MODE, {28'h0, hs, pd, st});
      fork
         axw(OFS_TXDATA, {23'h0, d});
         begin
            while (tx !== 1'h0 && k++ < 5000) @(negedge clk);
            repeat (p / 2) @(negedge clk);
            for (int i = 0; i < n; i++) begin
               chk(tx, f[i]);
               repeat (p) @(negedge clk);
            end
         end
      join
      // Let the last stop bit finish before the mode may change
      repeat (p) @(posedge clk);
      $display("tx test done pd=%0d st=%0d hs=%0d", pd, st, hs);
   endtask : t_tx

   task automatic t_rx(input logic [1:0] pd, input logic [8:0] d, input logic bad);
      int k;
      k = 0;
      axw(OFS_MODE, {29'h0, pd, 1'h0});
      i_rem.send(d, pd, 16, bad);
      do axr(OFS_STAT); while (rd[ST_RXDA] !== 1'h1 && ++k < 20);
      chk(rd[ST_RXDA], 1'h1);
      chk(rd[ST_PARITY_ERROR_FLAG], bad);
      axr(OFS_RXDATA);
      chk(rd, {23'h0, (pd == 2'h3) ? d : {1'h0, d[7:0]}});
      $display("rx test done pd=%0d bad=%0d", pd, bad);
   endtask : t_rx

   task automatic t_ir();
      axw(OFS_MODE, 32'h0000_1000);
      repeat (3) @(negedge clk);
      chk(tx, 1'h0);
      axw(OFS_MODE, 32'h0000_1008);
      repeat (3) @(negedge clk);
      chk(tx, 1'h1);
      $display("pulse coding test done");
   endtask : t_ir

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   initial begin
      #300_000;
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      axr(OFS_MODE);
      chk(rd, 32'h0);
      axw(OFS_MODE, 32'hFFFF);
      axr(OFS_MODE);
      chk(rd, {16'h0, MODE_WMASK});
      axr(8'h40);
      chk(rs, RESP_SLVERR);
      chk(rd, 32'h0);
      axw(8'h40, 32'h0);
      chk(rs, RESP_SLVERR);
      $display("register test done");
      axw(OFS_STAT, 32'h1 << ST_TXEN);
      for (int c = 0; c < 8; c++) t_tx(c[2:1], c[0], 1'h0, 9'h0A5 + 9'(c));
      t_tx(2'h3, 1'h1, 1'h1, 9'h15A);
      axw(OFS_IRQ_MSK, 32'h1 << EV_PARITY_ERROR_FLAG);
      t_rx(2'h1, 9'h03C, 1'h0);
      chk(irq, 1'h0);
      t_rx(2'h2, 9'h0C3, 1'h1);
      chk(irq, 1'h1);
      axw(OFS_IRQ_STS, 32'h1F);
      chk(irq, 1'h0);
      t_rx(2'h0, 9'h05A, 1'h0);
      t_rx(2'h3, 9'h1A5, 1'h0);
      t_ir();
      print_verdict();
   end
endmodule : tb_uart_frame_format_config
`default_nettype wire
